// *** shared/host_pin_pkg.sv ***
/*
  constants, state codes and sync bit layout for the host pin and
  configuration rom block.
  assumes a 100 MHz system clock and a microwire style 16-bit serial rom.
*/
package host_pin_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SK_SLOW_NS = 4000;
  localparam int SK_FAST_NS = 800;
  localparam logic [8:0] SK_SLOW_HALF = 9'(SK_SLOW_NS / CLK_PERIOD_NS / 2);
  localparam logic [8:0] SK_FAST_HALF = 9'(SK_FAST_NS / CLK_PERIOD_NS / 2);
  localparam logic [8:0] SYNC_SETTLE = 9'h003;
  localparam logic [1:0] SPEED_FAST = 2'h0;
  localparam logic [1:0] SPEED_SLOW = 2'h3;
  localparam logic [2:0] ROM_READ_OP = 3'h6;
  localparam int ROM_ADDR_W = 6;
  localparam int CMD_W = 9;
  localparam int WORD_W = 16;
  localparam logic [4:0] CMD_LAST = 5'h08;
  localparam logic [4:0] DATA_LAST = 5'h10;
  localparam logic [5:0] CFG_LAST_WORD = 6'h07;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  // synchronised pin bundle layout
  localparam int SY_W = 22;
  localparam int SY_EN = 21;
  localparam int SY_DIN = 20;
  localparam int SY_DIR = 19;
  localparam int SY_AEN = 18;
  localparam int SY_ADS = 17;
  localparam int SY_PD = 16;
  localparam int SY_W32 = 15;
  localparam int SY_ADDR_HI = 14;
  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_CMD = 3'h1,
    ST_DATA = 3'h3,
    ST_NEXT = 3'h2,
    ST_READY = 3'h6,
    ST_DOWN = 3'h7,
    ST_STRAP = 3'h4
  } state_e;
endpackage

// *** src/host_pin_ctrl.sv ***
/*
  host bus pin front end and serial configuration rom loader.
  assumes host bus strobe logic on sys_clk_in issues host_req_in, and that
  address, direction and qualifier pins are stable three cycles before it.
*/
module host_pin_ctrl (
  input wire logic sys_clk_in,
  input wire logic hardware_reset_n_in,
  input wire logic cfg_rom_enable_strap_in,
  input wire logic cfg_rom_data_in_in,
  input wire logic sync_write_read_dir_in,
  input wire logic address_qualifier_n_in,
  input wire logic address_latch_strobe_n_in,
  input wire logic full_chip_powerdown_n_in,
  input wire logic bus_32bit_strap_in,
  input wire logic [15:1] addr_in,
  input wire logic latch_mode_in,
  input wire logic [1:0] onchip_bus_speed_control_in,
  input wire logic host_req_in,
  output logic cfg_rom_serial_clock_out,
  output logic cfg_rom_select_out,
  output logic cfg_rom_data_out_out,
  output logic [15:0] cfg_word_out,
  output logic [5:0] cfg_word_index_out,
  output logic cfg_word_valid_out,
  output logic [1:0] bus_width_out,
  output logic cfg_done_out,
  output logic powerdown_out,
  output logic acc_valid_out,
  output logic acc_write_out,
  output logic [15:1] acc_addr_out
);
  typedef struct packed {
    host_pin_pkg::state_e st;
    logic [host_pin_pkg::SY_W-1:0] s1;
    logic [host_pin_pkg::SY_W-1:0] s2;
    logic ads_prev;
    logic [8:0] div;
    logic sk;
    logic cs;
    logic dout;
    logic [host_pin_pkg::CMD_W-1:0] cmd;
    logic [4:0] bitc;
    logic [5:0] idx;
    logic [15:0] shreg;
    logic [15:0] word;
    logic word_vld;
    logic [1:0] width;
    logic [15:1] lat_addr;
    logic lat_aen_n;
    logic done;
    logic acc_vld;
    logic acc_wr;
    logic [15:1] acc_addr;
  } state_s;

  state_s q, d;

  // speeds other than the two given fall back to the slow, always safe clock
  function automatic logic [8:0] half_count(input logic [1:0] speed);
    half_count = (speed == host_pin_pkg::SPEED_FAST) ? host_pin_pkg::SK_FAST_HALF
                                                    : host_pin_pkg::SK_SLOW_HALF;
  endfunction

  function automatic logic [host_pin_pkg::CMD_W-1:0] read_cmd(input logic [5:0] a);
    read_cmd = {host_pin_pkg::ROM_READ_OP, a};
  endfunction

  logic en_s, din_s, dir_s, aen_s, ads_s, pd_s, w32_s;
  logic [15:1] addr_s;
  logic aen_eff;
  logic [15:1] addr_eff;
  logic [8:0] half;
  assign en_s = q.s2[host_pin_pkg::SY_EN];
  assign din_s = q.s2[host_pin_pkg::SY_DIN];
  assign dir_s = q.s2[host_pin_pkg::SY_DIR];
  assign aen_s = q.s2[host_pin_pkg::SY_AEN];
  assign ads_s = q.s2[host_pin_pkg::SY_ADS];
  assign pd_s = q.s2[host_pin_pkg::SY_PD];
  assign w32_s = q.s2[host_pin_pkg::SY_W32];
  assign addr_s = q.s2[host_pin_pkg::SY_ADDR_HI:0];
  assign aen_eff = latch_mode_in ? q.lat_aen_n : aen_s;
  assign addr_eff = latch_mode_in ? q.lat_addr : addr_s;
  assign half = half_count(onchip_bus_speed_control_in);

  always_comb begin
    d = q;
    d.s1 = {cfg_rom_enable_strap_in, cfg_rom_data_in_in, sync_write_read_dir_in,
            address_qualifier_n_in, address_latch_strobe_n_in, full_chip_powerdown_n_in,
            bus_32bit_strap_in, addr_in};
    d.s2 = q.s1;
    d.ads_prev = ads_s;
    d.word_vld = 1'b0;
    d.acc_vld = 1'b0;
    if (ads_s && !q.ads_prev) begin
      d.lat_addr = addr_s;
      d.lat_aen_n = aen_s;
    end
    if (host_req_in && q.st == host_pin_pkg::ST_READY && !aen_eff) begin
      d.acc_vld = 1'b1;
      d.acc_wr = dir_s;
      d.acc_addr = addr_eff;
    end
    unique case (q.st)
      host_pin_pkg::ST_WAIT: begin
        d.div = q.div + 9'h001;
        if (q.div == host_pin_pkg::SYNC_SETTLE) begin
          d.div = 9'h000;
          if (en_s) begin
            d.st = host_pin_pkg::ST_CMD;
            d.idx = 6'h00;
            d.cmd = read_cmd(6'h00);
            d.dout = 1'b1;
            d.cs = 1'b1;
            d.sk = 1'b0;
            d.bitc = 5'h00;
          end else begin
            d.st = host_pin_pkg::ST_STRAP;
          end
        end
      end
      host_pin_pkg::ST_STRAP: begin
        d.width = w32_s ? host_pin_pkg::WIDTH_32 : (din_s ? host_pin_pkg::WIDTH_16 : host_pin_pkg::WIDTH_8);
        d.done = 1'b1;
        d.st = host_pin_pkg::ST_READY;
      end
      host_pin_pkg::ST_CMD, host_pin_pkg::ST_DATA: begin
        if (q.div >= half - 9'h001) begin
          d.div = 9'h000;
          d.sk = ~q.sk;
          if (!q.sk) begin
            d.bitc = q.bitc + 5'h01;
            if (q.st == host_pin_pkg::ST_CMD) begin
              if (q.bitc == host_pin_pkg::CMD_LAST) begin
                d.st = host_pin_pkg::ST_DATA;
                d.bitc = 5'h00;
              end
            end else begin
              d.shreg = {q.shreg[14:0], din_s};
              if (q.bitc == host_pin_pkg::DATA_LAST) begin
                d.word = {q.shreg[14:0], din_s};
                d.word_vld = 1'b1;
                d.st = host_pin_pkg::ST_NEXT;
                d.sk = 1'b0;
                d.cs = 1'b0;
                d.dout = 1'b0;
              end
            end
          end else if (q.st == host_pin_pkg::ST_CMD) begin
            d.cmd = {q.cmd[host_pin_pkg::CMD_W-2:0], 1'b0};
            d.dout = q.cmd[host_pin_pkg::CMD_W-2];
          end else begin
            d.dout = 1'b0;
          end
        end else begin
          d.div = q.div + 9'h001;
        end
      end
      host_pin_pkg::ST_NEXT: begin
        d.div = q.div + 9'h001;
        if (q.div >= half - 9'h001) begin
          d.div = 9'h000;
          if (q.idx == host_pin_pkg::CFG_LAST_WORD) begin
            d.st = host_pin_pkg::ST_READY;
            d.width = w32_s ? host_pin_pkg::WIDTH_32 : host_pin_pkg::WIDTH_16;
            d.done = 1'b1;
          end else begin
            d.idx = q.idx + 6'h01;
            d.cmd = read_cmd(q.idx + 6'h01);
            d.dout = 1'b1;
            d.cs = 1'b1;
            d.bitc = 5'h00;
            d.st = host_pin_pkg::ST_CMD;
          end
        end
      end
      host_pin_pkg::ST_READY: begin
      end
      host_pin_pkg::ST_DOWN: begin
        if (pd_s) begin
          d.st = host_pin_pkg::ST_WAIT;
          d.div = 9'h000;
        end
      end
      default: d.st = host_pin_pkg::ST_WAIT;
    endcase
    // configuration is lost in power-down; reload follows on wake
    if (q.st != host_pin_pkg::ST_WAIT && q.st != host_pin_pkg::ST_DOWN && !pd_s) begin
      d.st = host_pin_pkg::ST_DOWN;
      d.sk = 1'b0;
      d.cs = 1'b0;
      d.dout = 1'b0;
      d.done = 1'b0;
      d.acc_vld = 1'b0;
      d.word_vld = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge hardware_reset_n_in) begin
    if (!hardware_reset_n_in) begin
      q <= '0;
      // strobe and qualifier start at their idle high level: no false latch edge after reset
      q.s1[host_pin_pkg::SY_ADS] <= 1'b1;
      q.s2[host_pin_pkg::SY_ADS] <= 1'b1;
      q.s1[host_pin_pkg::SY_AEN] <= 1'b1;
      q.s2[host_pin_pkg::SY_AEN] <= 1'b1;
      q.ads_prev <= 1'b1;
      q.lat_aen_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cfg_rom_serial_clock_out = q.sk;
  assign cfg_rom_select_out = q.cs;
  assign cfg_rom_data_out_out = q.dout;
  assign cfg_word_out = q.word;
  assign cfg_word_index_out = q.idx;
  assign cfg_word_valid_out = q.word_vld;
  assign bus_width_out = q.width;
  assign cfg_done_out = q.done;
  assign powerdown_out = (q.st == host_pin_pkg::ST_DOWN);
  assign acc_valid_out = q.acc_vld;
  assign acc_write_out = q.acc_wr;
  assign acc_addr_out = q.acc_addr;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!hardware_reset_n_in);

  // power-down may cut any half period short, so it ends the check
  a_sk_fast_half: assert property (
    disable iff (!hardware_reset_n_in || !pd_s)
    $rose(q.sk) && q.st == host_pin_pkg::ST_CMD && q.bitc < host_pin_pkg::CMD_LAST &&
    onchip_bus_speed_control_in == host_pin_pkg::SPEED_FAST && pd_s |-> ##40 $fell(q.sk))
    else $error("fast rom clock half period wrong");
  a_sk_slow_half: assert property (
    disable iff (!hardware_reset_n_in || !pd_s)
    $rose(q.sk) && q.st == host_pin_pkg::ST_CMD && q.bitc < host_pin_pkg::CMD_LAST &&
    onchip_bus_speed_control_in == host_pin_pkg::SPEED_SLOW && pd_s |-> ##200 $fell(q.sk))
    else $error("slow rom clock half period wrong");
  a_cmd_start_bit: assert property ($rose(q.cs) |-> q.dout && q.st == host_pin_pkg::ST_CMD)
    else $error("rom command does not open with start bit");
  a_word_from_rom: assert property (q.word_vld |-> $past(q.st) == host_pin_pkg::ST_DATA && $past(en_s, 3))
    else $error("config word without rom read");
  a_strap_width: assert property (
    q.st == host_pin_pkg::ST_STRAP && !w32_s |=> q.width == ($past(din_s) ? host_pin_pkg::WIDTH_16
                                                                          : host_pin_pkg::WIDTH_8))
    else $error("bus width strap wrong");
  a_acc_dir: assert property (q.acc_vld |-> q.acc_wr == $past(dir_s))
    else $error("access direction mismatch");
  a_acc_qual: assert property (q.acc_vld |-> !$past(aen_eff))
    else $error("access taken with qualifier high");
  a_latch_addr: assert property (ads_s && !q.ads_prev |=> q.lat_addr == $past(addr_s))
    else $error("address not latched on strobe rise");
  a_pd_entry: assert property (
    !pd_s && q.st != host_pin_pkg::ST_WAIT |=> powerdown_out && !q.sk && !q.cs)
    else $error("power-down not entered");
  a_rom_choice: assert property (
    q.st == host_pin_pkg::ST_WAIT && q.div == host_pin_pkg::SYNC_SETTLE |=>
    q.st == ($past(en_s) ? host_pin_pkg::ST_CMD : host_pin_pkg::ST_STRAP))
    else $error("rom presence decision wrong");
  a_acc_after_cfg: assert property (q.acc_vld |-> q.done)
    else $error("access before configuration");

  c_rom_load: cover property (q.st == host_pin_pkg::ST_NEXT ##1 q.st == host_pin_pkg::ST_READY);
  c_strap_16: cover property (q.st == host_pin_pkg::ST_STRAP ##1 q.width == host_pin_pkg::WIDTH_16);
  c_write_acc: cover property (q.acc_vld && q.acc_wr);
  c_pd_wake: cover property (q.st == host_pin_pkg::ST_DOWN ##1 q.st == host_pin_pkg::ST_WAIT);
endmodule

// *** tb/cfg_rom_model.sv ***
/*
  serial config rom model: 9-bit read command, then a dummy 0 and 16 data bits.
  assumes select rises with the clock low and stays high for one whole read.
*/
module cfg_rom_model (
  input wire logic sk_in,
  input wire logic cs_in,
  input wire logic di_in,
  input wire logic [15:0] mem_in [8],
  output logic do_out,
  output logic [8:0] cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic bit_q;
  always @(posedge cs_in) begin
    cnt = 0;
    bit_q = 1'b0;
  end
  always @(posedge sk_in) begin
    if (cs_in) begin
      if (cnt < 9) cmd_out = {cmd_out[7:0], di_in};
      if (cnt >= 9 && cnt < 25) bit_q = mem_in[cmd_out[2:0]][24 - cnt];
      cnt++;
    end
  end
  // released line falls to the pull-down level
  assign do_out = cs_in ? bit_q : 1'b0;
endmodule

// *** tb/tb_host_pin_ctrl.sv ***
/*
  self-checking bench for host_pin_ctrl with the serial rom model.
  assumes a 100 MHz clock and the package constants.
*/
module tb_host_pin_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, hardware_reset_n = 1'b0, en = 1'b1, strap = 1'b0, dir = 1'b0, qn = 1'b1;
  logic ads_n = 1'b1, pd_n = 1'b1, w32 = 1'b0, lat = 1'b0, req = 1'b0, ok;
  logic [15:1] addr = 15'h0000, aa;
  logic [1:0] spd = 2'h3, bw;
  logic sk, cs, dout, wv, done, pd, av, aw, rom_do;
  logic [15:0] word, ea;
  logic [5:0] idx;
  logic [8:0] cmd;
  logic [15:0] mem [8];
  logic [21:0] wq [$];
  logic [21:0] ew;
  logic [15:0] aq [$];
  int error_cnt = 0, n_tests = 0, cyc = 0;
  time t0;
  host_pin_ctrl host_pin_ctrl_inst (.sys_clk_in(clk), .hardware_reset_n_in(hardware_reset_n), .cfg_rom_enable_strap_in(en),
    .cfg_rom_data_in_in(en ? rom_do : strap), .sync_write_read_dir_in(dir), .address_qualifier_n_in(qn),
    .address_latch_strobe_n_in(ads_n), .full_chip_powerdown_n_in(pd_n), .bus_32bit_strap_in(w32),
    .addr_in(addr), .latch_mode_in(lat), .onchip_bus_speed_control_in(spd), .host_req_in(req),
    .cfg_rom_serial_clock_out(sk), .cfg_rom_select_out(cs), .cfg_rom_data_out_out(dout),
    .cfg_word_out(word), .cfg_word_index_out(idx), .cfg_word_valid_out(wv), .bus_width_out(bw),
    .cfg_done_out(done), .powerdown_out(pd), .acc_valid_out(av), .acc_write_out(aw), .acc_addr_out(aa));
  cfg_rom_model cfg_rom_model_inst (.sk_in(sk), .cs_in(cs), .di_in(dout), .mem_in(mem), .do_out(rom_do),
    .cmd_out(cmd));
  initial forever #5 clk = ~clk;
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // covers the whole run with ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // sampled mid-cycle so flop updates have landed
  always @(negedge clk) begin
    if (wv === 1'b1) begin
      ok = wq.size() != 0;
      if (ok) ew = wq.pop_front();
      chk(ok && {idx, word} === ew && cmd === {host_pin_pkg::ROM_READ_OP, ew[21:16]}, "rom word");
    end
    if (av === 1'b1) begin
      ok = aq.size() != 0;
      if (ok) ea = aq.pop_front();
      chk(ok && {aw, aa} === ea, "host access");
    end
  end
  task automatic acc(input logic d, input logic q, input logic [15:1] a, input logic exp);
    @(posedge clk);
    dir <= d;
    qn <= q;
    addr <= a;
    repeat (4) @(posedge clk);
    // single-cycle request with idle gaps: host pace stays at half the clock or less
    req <= 1'b1;
    if (exp) aq.push_back({d, a});
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic latch(input logic q, input logic [15:1] a);
    qn <= q;
    addr <= a;
    ads_n <= 1'b0;
    repeat (4) @(posedge clk);
    ads_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_done(input int lim);
    int n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(done === 1'b1, "config not done");
  endtask
  task automatic sk_period(input time p);
    @(posedge sk);
    t0 = $time;
    @(posedge sk);
    chk($time - t0 == p, "rom clock period");
  endtask
  initial begin
    void'($urandom(32'h568a));
    foreach (mem[i]) mem[i] = 16'($urandom);
    repeat (12) @(posedge clk);
    hardware_reset_n <= 1'b1;
    @(posedge sk);
    sk_period(time'(host_pin_pkg::SK_SLOW_NS));
    acc(1'b1, 1'b0, 15'($urandom), 1'b0);
    pd_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(pd === 1'b1 && done === 1'b0 && cs === 1'b0 && sk === 1'b0, "power-down");
    acc(1'b0, 1'b0, 15'h0100, 1'b0);
    spd <= host_pin_pkg::SPEED_FAST;
    pd_n <= 1'b1;
    for (int i = 0; i < 8; i++) wq.push_back({6'(i), mem[i]});
    sk_period(time'(host_pin_pkg::SK_FAST_NS));
    wait_done(30000);
    chk(bw === host_pin_pkg::WIDTH_16 && pd === 1'b0 && wq.size() == 0, "rom load");
    for (int i = 0; i < 6; i++) acc(i[0], 1'b0, 15'($urandom), 1'b1);
    acc(1'b1, 1'b1, 15'($urandom), 1'b0);
    lat <= 1'b1;
    latch(1'b0, 15'h2a55);
    aq.push_back({1'b1, 15'h2a55});
    acc(1'b1, 1'b1, 15'h0001, 1'b0);
    latch(1'b1, 15'h1234);
    acc(1'b0, 1'b0, 15'h0002, 1'b0);
    lat <= 1'b0;
    en <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      strap <= (k != 0);
      w32 <= (k == 2);
      hardware_reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      hardware_reset_n <= 1'b1;
      wait_done(100);
      ew[1:0] = (k == 2) ? host_pin_pkg::WIDTH_32 : ((k == 1) ? host_pin_pkg::WIDTH_16 : host_pin_pkg::WIDTH_8);
      chk(cs === 1'b0 && bw === ew[1:0], "width strap");
    end
    repeat (5) @(posedge clk);
    chk(wq.size() == 0 && aq.size() == 0, "missing result");
    report_and_stop();
  end
endmodule
